// ==== bench/ffsm_conv_model.sv ====
// converter-side model: one conversion per go pulse, a one-cycle rail fault burst and a later one-cycle reference burst,
// then the data-ready fall pulse and a data read
// assumes go is a one-cycle pulse taken on pclk while the model is idle
`timescale 1ns/1ps
module ffsm_conv_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [3:0] rail_pat,
  input wire logic [1:0] ref_pat,
  output logic [3:0] rail_fault,
  output logic [1:0] ref_fault,
  output logic conv_end,
  output logic data_read,
  output logic busy
);
  logic [4:0] cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 5'h00;
      busy <= 1'b0;
      rail_fault <= 4'h0;
      ref_fault <= 2'h0;
      conv_end <= 1'b0;
      data_read <= 1'b0;
    end
    else
    begin
      if (go)
        cnt <= 5'h00;
      else if (busy)
        cnt <= cnt + 5'h01;
      // faults last one cycle only, so the bank must hold them to the end
      rail_fault <= (busy && cnt == 5'h04) ? rail_pat : 4'h0;
      // reference burst sits in the last cycle before the end pulse, a single brief floating check
      ref_fault <= (busy && cnt == 5'h09) ? ref_pat : 2'h0;
      conv_end <= busy && cnt == 5'h0A;
      data_read <= busy && cnt == 5'h0C;
      busy <= go || (busy && cnt != 5'h0E);
    end
  end
endmodule

// ==== bench/tb_top.sv ====
// testbench: apb master, conversion model, register, routing and fault flag checks
// assumes one apb wait state and config outputs two cycles behind a write
`timescale 1ns/1ps
module tb_top;
  import ffsm_pkg::*;
  localparam int SU = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go, busy, conv_end, data_read;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] rail_fault, rail_pat;
  logic [1:0] ref_fault, ref_pat, reference_monitor_enable, burnout_current_source;
  logic bias_level_select, ext_inputs_connect, burnout_enable, rail_monitor_enable, prepend_flags_enable;
  logic [6:0] bias_input_connect;
  logic [2:0] monitor_source_select, effective_gain;
  logic [7:0] prepend_byte, g, fl, v;
  logic [12:0] em;
  logic [11:0] ra [5] = '{12'h00C, 12'h014, 12'h018, 12'h020, 12'h024};
  int err_total, samples_checked;

  ffsm_top #(.STARTUP_CYC(SU)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rail_fault, .ref_fault, .conv_end, .data_read, .bias_level_select,
    .bias_input_connect, .ext_inputs_connect, .monitor_source_select, .burnout_current_source,
    .burnout_enable, .effective_gain, .rail_monitor_enable, .reference_monitor_enable,
    .prepend_flags_enable, .prepend_byte);
  ffsm_conv_model u_far (.pclk, .presetn, .go, .rail_pat, .ref_pat, .rail_fault, .ref_fault, .conv_end,
    .data_read, .busy);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic hang_if(input int n);
    if (n >= 100)
    begin
      chk(0, 1, "wait ran out");
      give_verdict();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    hang_if(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk({err, rd}, {1'b0, exp}, m);
  endtask

  task automatic conv(input logic [3:0] r, input logic [1:0] f);
    int n;
    n = 0;
    @(posedge pclk);
    rail_pat <= r;
    ref_pat <= f;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (busy === 1'b1 && n < 100);
    hang_if(n);
  endtask

  function automatic logic [12:0] exp_mon(input logic [2:0] c, input logic [7:0] gn);
    logic bo;
    bo = c >= 3'h5;
    return {bo, bo ? 2'(c - 3'h5) : 2'h0, !(c inside {[3'h1:3'h4]}),
      (c == 3'h3 || c == 3'h4) ? FFSM_GAIN_ONE : gn[2:0], 3'h0, c};
  endfunction

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, go, paddr, pwdata, rail_pat, ref_pat} = '0;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(32'h75582FC7));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h020, 32'h0000_00FF);
    rdc(12'h020, 32'h0, "write before ready");
    rdc(12'h004, 32'hC0, "flags after start-up");
    for (int i = 0; i < 5; i++)
    begin
      rdc(ra[i], 32'h0, "reset value");
      v = 8'($urandom);
      apb(1'b1, ra[i], {24'hABCDEF, v});
      rdc(ra[i], {24'h0, v}, "readback");
    end
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1, "unmapped read");
    apb(1'b0, 12'h005, 32'h0);
    chk(err, 1'b1, "unaligned read");
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      apb(1'b1, 12'h020, {24'h0, v});
      repeat (2) @(posedge pclk);
      chk(bias_level_select, v[6], "bias level");
      chk(bias_input_connect, {v[7], v[5:0]}, "bias inputs");
    end
    $display("test bias done");
    for (int c = 0; c < 8; c++)
    begin
      g = 8'($urandom);
      if (c == 2)
        g[2:0] = {1'b0, g[1], 1'b0};
      apb(1'b1, 12'h00C, {24'h0, g});
      apb(1'b1, 12'h024, {24'h0, c[2:0], 5'h00});
      repeat (2) @(posedge pclk);
      em = exp_mon(c[2:0], g);
      chk({burnout_enable, burnout_current_source}, em[12:10], "burn-out");
      chk({ext_inputs_connect, effective_gain}, em[9:6], "routing");
      chk(monitor_source_select, em[2:0], "monitor select");
      rdc(12'h080, {19'h0_0000, em}, "monitor status");
    end
    $display("test monitor done");
    for (int i = 0; i < 8; i++)
    begin
      v = (i < 2) ? {8{i[0]}} : 8'($urandom);
      apb(1'b1, 12'h018, {24'h0, v[0], 7'h00});
      apb(1'b1, 12'h014, {24'h0, v[2:1], 6'h00});
      // monitor code 000: no burn-out current during the measured conversions
      apb(1'b1, 12'h024, {24'h0, 7'h00, v[3]});
      repeat (4) @(posedge pclk);
      conv((i == 0) ? 4'hF : v[7:4], (i == 0) ? 2'h3 : v[5:4]);
      fl = {2'b11, v[7:4] & {4{v[0]}}, v[5:4] & {2{|v[2:1]}}};
      if (i == 0)
        fl[5:0] = 6'h0;
      chk(rail_monitor_enable, v[0], "rail enable");
      chk({reference_monitor_enable, prepend_flags_enable}, {v[2:1], v[3]}, "enables");
      rdc(12'h004, fl, "latched flags");
      chk(prepend_byte, v[3] ? fl : 8'h00, "prepended byte");
    end
    $display("test flags done");
    apb(1'b1, 12'h004, 32'h0000_00FF);
    rdc(12'h004, fl, "flag write with bit7 set");
    apb(1'b1, 12'h004, 32'h0);
    rdc(12'h004, {1'b0, fl[6:0]}, "power-on flag cleared");
    $display("test power-on flag done");
    give_verdict();
  end
endmodule

// ==== rtl/ffsm_fault_latch.sv ====
// fault latch: gathers faults across one conversion, publishes at its end
// assumes conv_end is a one-cycle pulse marking the falling edge of data ready
`timescale 1ns/1ps
module ffsm_fault_latch
  import ffsm_pkg::*;
#(
  parameter int W = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [W-1:0] fault_in,
  input wire logic conv_end,
  output logic [W-1:0] flags
);
  typedef struct packed
  {
    logic [W-1:0] acc;
    logic [W-1:0] flags;
  } ffsm_fl_st_t;
  ffsm_fl_st_t st_reg;
  ffsm_fl_st_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (conv_end)
    begin
      // fault arriving in the last cycle still counts for this conversion
      st_next.flags = st_reg.acc | (enable ? fault_in : '0);
      st_next.acc = '0;
    end
    else if (enable)
    begin
      st_next.acc = st_reg.acc | fault_in;
    end
    if (!enable && conv_end)
      st_next.flags = '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign flags = st_reg.flags;

  property p_hold_between;
    @(posedge pclk) disable iff (!presetn) !conv_end |=> flags == $past(flags);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("flags moved mid conversion");

  property p_capture;
    @(posedge pclk) disable iff (!presetn) (enable && |fault_in && !conv_end) ##1 (enable && conv_end) |=> |flags;
  endproperty
  a_capture: assert property (p_capture) else $error("fault lost at conversion end");
endmodule

// ==== rtl/ffsm_pkg.sv ====
// package: register map, field positions and reset values of the fault flag and monitor bank
// assumes byte-wide registers, one per aligned 32-bit apb word
package ffsm_pkg;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] FFSM_IDX_FLAGS = 8'h01;
  localparam logic [7:0] FFSM_IDX_GAIN = 8'h03;
  localparam logic [7:0] FFSM_IDX_REFCTL = 8'h05;
  localparam logic [7:0] FFSM_IDX_EXC1 = 8'h06;
  localparam logic [7:0] FFSM_IDX_BIAS = 8'h08;
  localparam logic [7:0] FFSM_IDX_SYSCTL = 8'h09;
  localparam logic [7:0] FFSM_IDX_STAT = 8'h20;
  // flag byte bits
  localparam int FFSM_FLAG_POWERON = 7;
  localparam int FFSM_FL_RDY = 6;
  localparam int FFSM_FL_PH = 5;
  localparam int FFSM_FL_PL = 4;
  localparam int FFSM_FL_NH = 3;
  localparam int FFSM_FL_NL = 2;
  localparam int FFSM_FL_R3 = 1;
  localparam int FFSM_FL_R0 = 0;
  // sensor biasing: bit 6 level, bits 5..0 hold inputs 0..5, bit 7 common input
  localparam int FFSM_BIAS_LVL = 6;
  localparam int FFSM_BIAS_COM = 7;
  // system control: monitor select [7:5], prepend flags bit 0
  localparam int FFSM_SYS_SRC_LSB = 5;
  localparam int FFSM_SYS_SEND = 0;
  // reference control: monitor enable [7:6]
  localparam int FFSM_REF_EN_LSB = 6;
  // excitation 1: rail monitor enable bit 7
  localparam int FFSM_EXC_RAIL_EN = 7;
  // gain: amplifier enable [6:5], gain code [2:0]
  localparam int FFSM_GAIN_EN_LSB = 5;
  localparam logic [2:0] FFSM_GAIN_ONE = 3'h0;
  localparam logic [7:0] FFSM_RST_GAIN = 8'h00;
  localparam logic [7:0] FFSM_RST_REFCTL = 8'h00;
  localparam logic [7:0] FFSM_RST_EXC1 = 8'h00;
  localparam logic [7:0] FFSM_RST_BIAS = 8'h00;
  localparam logic [7:0] FFSM_RST_SYSCTL = 8'h00;
  // start-up cycles before the ready flag rises
  localparam int FFSM_STARTUP_CYC = 16;
  typedef enum logic [2:0]
  {
    FFSM_MON_OFF = 3'h0,
    FFSM_MON_MID = 3'h1,
    FFSM_MON_TEMP = 3'h2,
    FFSM_MON_AVDD = 3'h3,
    FFSM_MON_DVDD = 3'h4,
    FFSM_MON_BO02 = 3'h5,
    FFSM_MON_BO1 = 3'h6,
    FFSM_MON_BO10 = 3'h7
  } ffsm_mon_t;
endpackage

// ==== rtl/ffsm_top.sv ====
// fault flag and system monitor register bank with apb slave
// assumes analog fault comparators and conversion-end pulse arrive synchronous to pclk
`timescale 1ns/1ps
module ffsm_top
  import ffsm_pkg::*;
#(
  parameter int STARTUP_CYC = FFSM_STARTUP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] rail_fault,
  input wire logic [1:0] ref_fault,
  input wire logic conv_end,
  input wire logic data_read,
  output logic bias_level_select,
  output logic [6:0] bias_input_connect,
  output logic ext_inputs_connect,
  output logic [2:0] monitor_source_select,
  output logic [1:0] burnout_current_source,
  output logic burnout_enable,
  output logic [2:0] effective_gain,
  output logic rail_monitor_enable,
  output logic [1:0] reference_monitor_enable,
  output logic prepend_flags_enable,
  output logic [7:0] prepend_byte
);
  localparam int CW = $clog2(STARTUP_CYC + 1);

  typedef struct packed
  {
    logic [7:0] gain;
    logic [7:0] refctl;
    logic [7:0] exc1;
    logic [7:0] bias;
    logic [7:0] sysctl;
    logic por;
    logic rdy;
    logic [CW-1:0] cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bias_lvl;
    logic [6:0] bias_conn;
    logic ext_conn;
    logic [2:0] mon;
    logic [1:0] bo_sel;
    logic bo_en;
    logic [2:0] eff_gain;
    logic rail_en;
    logic [1:0] ref_en;
    logic send;
    logic [7:0] pre_byte;
  } ffsm_st_t;

  ffsm_st_t st_reg;
  ffsm_st_t st_next;
  logic [3:0] rail_flags;
  logic [1:0] ref_flags;
  logic [7:0] flag_byte;

  // registers sit on word boundaries; anything else is unmapped
  function automatic logic [7:0] ffsm_idx(input logic [11:0] a);
    ffsm_idx = a[9:2];
  endfunction

  ffsm_fault_latch #(.W(4)) u_rail
  (
    .pclk(pclk),
    .presetn(presetn),
    .enable(st_reg.exc1[FFSM_EXC_RAIL_EN]),
    .fault_in(rail_fault),
    .conv_end(conv_end),
    .flags(rail_flags)
  );

  ffsm_fault_latch #(.W(2)) u_ref
  (
    .pclk(pclk),
    .presetn(presetn),
    .enable(|st_reg.refctl[FFSM_REF_EN_LSB +: 2]),
    .fault_in(ref_fault),
    .conv_end(conv_end),
    .flags(ref_flags)
  );

  assign flag_byte = {st_reg.por, st_reg.rdy, rail_flags, ref_flags};

  always_comb
  begin
    logic acc;
    logic [7:0] idx;
    logic mapped;
    logic [2:0] m;
    acc = psel && penable && !st_reg.pready;
    idx = ffsm_idx(paddr);
    mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
             (idx == FFSM_IDX_FLAGS || idx == FFSM_IDX_GAIN || idx == FFSM_IDX_REFCTL ||
              idx == FFSM_IDX_EXC1 || idx == FFSM_IDX_BIAS || idx == FFSM_IDX_SYSCTL ||
              idx == FFSM_IDX_STAT);
    m = st_reg.sysctl[FFSM_SYS_SRC_LSB +: 3];
    st_next = st_reg;
    st_next.pready = acc;
    st_next.pslverr = acc && !mapped;
    st_next.prdata = 32'h0000_0000;
    // start-up counter drives the ready flag
    if (!st_reg.rdy)
    begin
      if (st_reg.cnt == CW'(STARTUP_CYC))
        st_next.rdy = 1'b1;
      else
        st_next.cnt = st_reg.cnt + CW'(1);
    end
    if (acc && mapped)
    begin
      if (pwrite)
      begin
        // configuration writes refused until start-up completes
        if (st_reg.rdy)
        begin
          unique case (idx)
            FFSM_IDX_FLAGS:
            begin
              if (!pwdata[FFSM_FLAG_POWERON])
                st_next.por = 1'b0;
            end
            FFSM_IDX_GAIN: st_next.gain = pwdata[7:0];
            FFSM_IDX_REFCTL: st_next.refctl = pwdata[7:0];
            FFSM_IDX_EXC1: st_next.exc1 = pwdata[7:0];
            FFSM_IDX_BIAS: st_next.bias = pwdata[7:0];
            FFSM_IDX_SYSCTL: st_next.sysctl = pwdata[7:0];
            default: st_next.por = st_reg.por;
          endcase
        end
      end
      else
      begin
        unique case (idx)
          FFSM_IDX_FLAGS: st_next.prdata = {24'h00_0000, flag_byte};
          FFSM_IDX_GAIN: st_next.prdata = {24'h00_0000, st_reg.gain};
          FFSM_IDX_REFCTL: st_next.prdata = {24'h00_0000, st_reg.refctl};
          FFSM_IDX_EXC1: st_next.prdata = {24'h00_0000, st_reg.exc1};
          FFSM_IDX_BIAS: st_next.prdata = {24'h00_0000, st_reg.bias};
          FFSM_IDX_SYSCTL: st_next.prdata = {24'h00_0000, st_reg.sysctl};
          default: st_next.prdata = {19'h0_0000, st_reg.bo_en, st_reg.bo_sel, st_reg.ext_conn,
                                     st_reg.eff_gain, 3'h0, st_reg.mon};
        endcase
      end
    end
    // analog routing decoded from the settled registers
    st_next.mon = m;
    st_next.bias_lvl = st_reg.bias[FFSM_BIAS_LVL];
    st_next.bias_conn = {st_reg.bias[FFSM_BIAS_COM], st_reg.bias[5:0]};
    st_next.ext_conn = 1'b1;
    st_next.bo_en = 1'b0;
    st_next.bo_sel = 2'h0;
    st_next.eff_gain = st_reg.gain[2:0];
    unique case (ffsm_mon_t'(m))
      FFSM_MON_OFF: st_next.ext_conn = 1'b1;
      FFSM_MON_MID: st_next.ext_conn = 1'b0;
      FFSM_MON_TEMP: st_next.ext_conn = 1'b0;
      FFSM_MON_AVDD, FFSM_MON_DVDD:
      begin
        st_next.ext_conn = 1'b0;
        st_next.eff_gain = FFSM_GAIN_ONE;
      end
      FFSM_MON_BO02, FFSM_MON_BO1, FFSM_MON_BO10:
      begin
        st_next.bo_en = 1'b1;
        st_next.bo_sel = m[1:0] - 2'h1;
      end
    endcase
    st_next.rail_en = st_reg.exc1[FFSM_EXC_RAIL_EN];
    st_next.ref_en = st_reg.refctl[FFSM_REF_EN_LSB +: 2];
    st_next.send = st_reg.sysctl[FFSM_SYS_SEND];
    // byte to prepend is frozen at the data read strobe
    if (data_read)
      st_next.pre_byte = st_reg.sysctl[FFSM_SYS_SEND] ? flag_byte : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.gain <= FFSM_RST_GAIN;
      st_reg.refctl <= FFSM_RST_REFCTL;
      st_reg.exc1 <= FFSM_RST_EXC1;
      st_reg.bias <= FFSM_RST_BIAS;
      st_reg.sysctl <= FFSM_RST_SYSCTL;
      st_reg.por <= 1'b1;
      st_reg.ext_conn <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign bias_level_select = st_reg.bias_lvl;
  assign bias_input_connect = st_reg.bias_conn;
  assign ext_inputs_connect = st_reg.ext_conn;
  assign monitor_source_select = st_reg.mon;
  assign burnout_current_source = st_reg.bo_sel;
  assign burnout_enable = st_reg.bo_en;
  assign effective_gain = st_reg.eff_gain;
  assign rail_monitor_enable = st_reg.rail_en;
  assign reference_monitor_enable = st_reg.ref_en;
  assign prepend_flags_enable = st_reg.send;
  assign prepend_byte = st_reg.pre_byte;

  property p_por_sticky;
    @(posedge pclk) disable iff (!presetn)
      st_reg.por && !(psel && penable && pwrite && paddr == 12'h004 && !pwdata[7]) |=> st_reg.por;
  endproperty
  a_por_sticky: assert property (p_por_sticky) else $error("power-on flag lost without write");

  property p_supply_gain;
    @(posedge pclk) disable iff (!presetn)
      (st_reg.sysctl[7:5] == 3'h3 || st_reg.sysctl[7:5] == 3'h4) ##1 $stable(st_reg.sysctl)
      |-> effective_gain == 3'h0 && !ext_inputs_connect;
  endproperty
  a_supply_gain: assert property (p_supply_gain) else $error("supply monitor gain not one");

  property p_temp_route;
    @(posedge pclk) disable iff (!presetn)
      st_reg.sysctl[7:5] == 3'h2 |=> !ext_inputs_connect && effective_gain == $past(st_reg.gain[2:0]);
  endproperty
  a_temp_route: assert property (p_temp_route) else $error("temperature routing wrong");

  property p_burnout;
    @(posedge pclk) disable iff (!presetn)
      st_reg.sysctl[7:5] == 3'h7 |=> burnout_enable && burnout_current_source == 2'h2;
  endproperty
  a_burnout: assert property (p_burnout) else $error("10 uA burn-out not selected");

  property p_off_clean;
    @(posedge pclk) disable iff (!presetn)
      st_reg.sysctl[7:5] == 3'h0 |=> !burnout_enable && ext_inputs_connect;
  endproperty
  a_off_clean: assert property (p_off_clean) else $error("code 000 not clean");

  property p_mid;
    @(posedge pclk) disable iff (!presetn) st_reg.sysctl[7:5] == 3'h1 |=> !ext_inputs_connect;
  endproperty
  a_mid: assert property (p_mid) else $error("mid-scale not selected");

  property p_bias;
    @(posedge pclk) disable iff (!presetn) 1'b1 |=> bias_level_select == $past(st_reg.bias[6]);
  endproperty
  a_bias: assert property (p_bias) else $error("bias level mismatch");

  property p_rdy;
    @(posedge pclk) disable iff (!presetn) st_reg.rdy |=> st_reg.rdy;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready flag dropped");

  property p_apb_one_wait;
    @(posedge pclk) disable iff (!presetn) (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait) else $error("apb answer timing wrong");

  property p_bias_conn;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> bias_input_connect == {$past(st_reg.bias[FFSM_BIAS_COM]), $past(st_reg.bias[5:0])};
  endproperty
  a_bias_conn: assert property (p_bias_conn) else $error("bias input connection mismatch");

  property p_temp_sel;
    @(posedge pclk) disable iff (!presetn)
      st_reg.sysctl[7:5] == 3'h2 |=> monitor_source_select == 3'h2 && !burnout_enable;
  endproperty
  a_temp_sel: assert property (p_temp_sel) else $error("temperature sensor not selected");

  property p_supply_sel;
    @(posedge pclk) disable iff (!presetn)
      (st_reg.sysctl[7:5] == 3'h3 || st_reg.sysctl[7:5] == 3'h4)
      |=> monitor_source_select == $past(st_reg.sysctl[7:5]) && !burnout_enable;
  endproperty
  a_supply_sel: assert property (p_supply_sel) else $error("supply monitor not selected");

  property p_burnout_low;
    @(posedge pclk) disable iff (!presetn)
      st_reg.sysctl[7:5] == 3'h5 |=> burnout_enable && burnout_current_source == 2'h0;
  endproperty
  a_burnout_low: assert property (p_burnout_low) else $error("0.2 uA burn-out not selected");

  property p_burnout_mid;
    @(posedge pclk) disable iff (!presetn)
      st_reg.sysctl[7:5] == 3'h6 |=> burnout_enable && burnout_current_source == 2'h1;
  endproperty
  a_burnout_mid: assert property (p_burnout_mid) else $error("1 uA burn-out not selected");

  property p_prepend;
    @(posedge pclk) disable iff (!presetn)
      data_read |=> prepend_byte == ($past(st_reg.sysctl[FFSM_SYS_SEND]) ? $past(flag_byte) : 8'h00);
  endproperty
  a_prepend: assert property (p_prepend) else $error("prepended flag byte wrong");

  property p_flag_read;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && !pwrite && paddr == 12'h004
      |=> prdata == {24'h00_0000, $past(flag_byte)};
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag byte read wrong");

  // a write that arrives while the map is still coming up must leave gain, refctl, bias, sysctl and the power-on flag alone
  property p_no_early_config;
    @(posedge pclk) disable iff (!presetn)
      !st_reg.rdy && psel && penable && !pready && pwrite
      |=> $stable(st_reg.gain) && $stable(st_reg.refctl) && $stable(st_reg.bias) && $stable(st_reg.sysctl) && st_reg.por;
  endproperty
  a_no_early_config: assert property (p_no_early_config) else $error("write taken before ready");

  property p_ready_rise;
    @(posedge pclk) disable iff (!presetn)
      !st_reg.rdy && st_reg.cnt == CW'(STARTUP_CYC) |=> st_reg.rdy;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready flag late");

  property p_enables;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> rail_monitor_enable == $past(st_reg.exc1[FFSM_EXC_RAIL_EN])
      && reference_monitor_enable == $past(st_reg.refctl[7:6]);
  endproperty
  a_enables: assert property (p_enables) else $error("monitor enable outputs wrong");
endmodule
